/* shared/halt_sub_map.vh */
// Purpose: Offsets, fields, reset values and codes for the halt/subtract unit
// Assumes: 32-bit AXI4-Lite register window, one aligned word per register
// Notes: Included by bare name
`ifndef HALT_SUB_MAP_VH
`define HALT_SUB_MAP_VH

// Register byte offsets
`define CTRL_OFS 4'h0
`define INSTR_OFS 4'h4
`define ACC_OFS 4'h8
`define STATUS_OFS 4'hC

// Opcode encodings (14-bit words)
`define OPC_HALT 14'h0063
`define OPC_SUBL_MASK 14'h3E00
`define OPC_SUBL_VAL 14'h3C00

// Control register fields
`define CTRL_WAKE_BIT 0
`define CTRL_WATCHDOG_CLR_BIT 1

// Status register fields
`define ST_CARRY_BIT 0
`define ST_POWERDOWN_BIT 1
`define ST_TIMEOUT_BIT 2
`define ST_SLEEP_BIT 3
`define ST_BUSY_BIT 4

// Reset values
`define ACC_RST 8'h00
`define WATCHDOG_RST 8'h00
`define PRESC_RST 8'h00
`define TIMEOUT_RST 1'b1
`define POWERDOWN_RST 1'b1

// Response codes
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* src/wdt_count.v */
// Purpose: Watchdog counter with prescaler, cleared on request
// Assumes: Same clock as the core, synchronous active-low reset
// Notes: Prescaler is an 8-bit divider that runs only while i_run is high; counter ticks on wrap
`timescale 1ns/1ps
`include "halt_sub_map.vh"

module watchdog_count
(
  input wire i_clk,
  input wire i_rstn,
  input wire i_ce,
  input wire i_run,
  input wire i_clr,
  output reg [7:0] o_count,
  output reg [7:0] o_presc
);

  always @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      o_count <= `WATCHDOG_RST;
      o_presc <= `PRESC_RST;
    end
    else if (i_ce)
    begin
      if (i_clr)
      begin
        o_count <= 8'h00;
        o_presc <= 8'h00;
      end
      else if (i_run)
      begin
        o_presc <= o_presc + 8'h01;
        if (o_presc == 8'hFF)
          o_count <= o_count + 8'h01;
      end
    end
  end

endmodule

/* src/halt_sub_exec.v */
// Purpose: Executes the halt and literal-minus-accumulator instructions
// Assumes: Software issues opcodes through an AXI4-Lite slave
// Notes: Sleep freezes the watchdog and holds the oscillator off until wake
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "halt_sub_map.vh"

// What this block does
// - Opcode 0x0063 halts, oscillator stops
// - Halt clears watchdog counter and prescaler
// - Halt sets timeout flag, carry and accumulator untouched
// - Halt clears powerdown flag
// - Zero difference: carry one, accumulator zero
// - Negative difference: carry zero, wrapped result
module halt_sub_exec
(
  input wire i_clk,
  input wire i_rstn,
  input wire i_ce,
  input wire [3:0] i_awaddr,
  input wire i_awvalid,
  output reg o_awready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output reg o_wready,
  output reg [1:0] o_bresp,
  output reg o_bvalid,
  input wire i_bready,
  input wire [3:0] i_araddr,
  input wire i_arvalid,
  output reg o_arready,
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  output reg o_rvalid,
  input wire i_rready,
  output reg o_osc_en,
  output reg o_sleep
);

  function is_halt;
    input [13:0] op;
    begin
      is_halt = (op == `OPC_HALT);
    end
  endfunction

  function is_subl;
    input [13:0] op;
    begin
      is_subl = ((op & `OPC_SUBL_MASK) == `OPC_SUBL_VAL);
    end
  endfunction

  // Execute states
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_EXEC = 2'h1;
  localparam [1:0] S_HALTED = 2'h2;

  reg [1:0] state_r;
  reg [13:0] instr_r;
  reg [7:0] acc_r;
  reg carry_r;
  reg timeout_r;
  reg powerdown_r;
  reg watchdog_clr_r;
  reg [3:0] aw_r;
  reg aw_have_r;
  reg [31:0] wd_r;
  reg [3:0] ws_r;
  reg w_have_r;
  wire [7:0] watchdog_value;
  wire [7:0] watchdog_presc;
  wire [8:0] diff;
  wire do_write;

  assign diff = {1'b0, instr_r[7:0]} - {1'b0, acc_r};
  assign do_write = aw_have_r && w_have_r && !o_bvalid;

  watchdog_count u_watchdog
  (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_run(state_r != S_HALTED),
    .i_clr(watchdog_clr_r),
    .o_count(watchdog_value),
    .o_presc(watchdog_presc)
  );

  // Write channel: address and data captured in either order
  always @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_r <= 4'h0;
      wd_r <= 32'h0000_0000;
      ws_r <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= `RESP_OKAY;
    end
    else if (i_ce)
    begin
      if (o_awready && i_awvalid)
      begin
        aw_r <= i_awaddr;
        aw_have_r <= 1'b1;
        o_awready <= 1'b0;
      end
      if (o_wready && i_wvalid)
      begin
        wd_r <= i_wdata;
        ws_r <= i_wstrb;
        w_have_r <= 1'b1;
        o_wready <= 1'b0;
      end
      if (do_write)
      begin
        o_bvalid <= 1'b1;
        o_bresp <= (aw_r == `CTRL_OFS || aw_r == `INSTR_OFS ||
          aw_r == `ACC_OFS) ? `RESP_OKAY : `RESP_SLVERR;
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
      end
      if (o_bvalid && i_bready)
      begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  // Execute engine; an opcode write is only taken when idle
  always @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      state_r <= S_IDLE;
      instr_r <= 14'h0000;
      acc_r <= `ACC_RST;
      carry_r <= 1'b0;
      timeout_r <= `TIMEOUT_RST;
      powerdown_r <= `POWERDOWN_RST;
      watchdog_clr_r <= 1'b0;
      o_osc_en <= 1'b1;
      o_sleep <= 1'b0;
    end
    else if (i_ce)
    begin
      watchdog_clr_r <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          if (do_write && aw_r == `INSTR_OFS && ws_r[1:0] == 2'b11)
          begin
            instr_r <= wd_r[13:0];
            state_r <= S_EXEC;
          end
          else if (do_write && aw_r == `ACC_OFS && ws_r[0])
            acc_r <= wd_r[7:0];
          else if (do_write && aw_r == `CTRL_OFS && ws_r[0] &&
            wd_r[`CTRL_WATCHDOG_CLR_BIT])
            watchdog_clr_r <= 1'b1;
        end
        S_EXEC:
        begin
          state_r <= S_IDLE;
          if (is_halt(instr_r))
          begin
            watchdog_clr_r <= 1'b1;
            timeout_r <= 1'b1;
            powerdown_r <= 1'b0;
            o_osc_en <= 1'b0;
            o_sleep <= 1'b1;
            state_r <= S_HALTED;
          end
          else if (is_subl(instr_r))
          begin
            acc_r <= diff[7:0];
            carry_r <= ~diff[8];
          end
        end
        S_HALTED:
        begin
          // Wake is a software stand-in for the external wake sources
          if (do_write && aw_r == `CTRL_OFS && ws_r[0] &&
            wd_r[`CTRL_WAKE_BIT])
          begin
            o_osc_en <= 1'b1;
            o_sleep <= 1'b0;
            state_r <= S_IDLE;
          end
        end
        default:
          state_r <= S_IDLE;
      endcase
    end
  end

  // Read channel
  always @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `RESP_OKAY;
    end
    else if (i_ce)
    begin
      if (o_arready && i_arvalid)
      begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        o_rresp <= `RESP_OKAY;
        case (i_araddr)
          `CTRL_OFS: o_rdata <= {16'h0000, watchdog_presc, watchdog_value};
          `INSTR_OFS: o_rdata <= {18'h0_0000, instr_r};
          `ACC_OFS: o_rdata <= {24'h00_0000, acc_r};
          `STATUS_OFS: o_rdata <= {27'h000_0000, state_r == S_EXEC,
            o_sleep, timeout_r, powerdown_r, carry_r};
          default:
          begin
            o_rdata <= 32'h0000_0000;
            o_rresp <= `RESP_SLVERR;
          end
        endcase
      end
      else if (o_rvalid && i_rready)
      begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end

endmodule

/* sim/halt_sub_props.sv */
// Purpose: Port checks for the halt/subtract unit
// Assumes: Bound to halt_sub_exec
// Notes: Flag effects are checked through bench reads
`timescale 1ns/1ps
module halt_sub_props
(
  input wire i_clk,
  input wire i_rstn,
  input wire i_ce,
  input wire i_bready,
  input wire o_awready,
  input wire o_wready,
  input wire o_bvalid,
  input wire o_arready,
  input wire o_rvalid,
  input wire o_osc_en,
  input wire o_sleep
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  osc_stop_a: assert property (o_osc_en == !o_sleep)
    else $error("oscillator state disagrees with sleep");
  // Wake lands on the same edge as the wake write's response
  sleep_hold_a: assert property ($fell(o_sleep) |->
    $rose(o_bvalid))
    else $error("sleep left without a write");
  one_cycle_a: assert property ($rose(o_sleep) |->
    $past(o_bvalid) || $past(o_bvalid, 2))
    else $error("halt took too long");
  sleep_entry_a: assert property ($rose(o_sleep) |->
    $fell(o_osc_en))
    else $error("oscillator kept running into sleep");
  osc_wake_a: assert property ($rose(o_osc_en) |->
    $fell(o_sleep))
    else $error("oscillator restarted while asleep");
  write_free_a: assert property (o_bvalid && i_bready && i_ce |=>
    !o_bvalid && o_awready && o_wready)
    else $error("write channel not freed after response");
  read_answer_a: assert property ($fell(o_arready) |-> o_rvalid)
    else $error("read data late");
endmodule
bind halt_sub_exec halt_sub_props u_props
(
  .i_clk(i_clk),
  .i_rstn(i_rstn),
  .i_ce(i_ce),
  .i_bready(i_bready),
  .o_awready(o_awready),
  .o_wready(o_wready),
  .o_bvalid(o_bvalid),
  .o_arready(o_arready),
  .o_rvalid(o_rvalid),
  .o_osc_en(o_osc_en),
  .o_sleep(o_sleep)
);

/* sim/sleep_instr_and_sub_carry_tb.sv */
// Purpose: Self-checking bench for the halt/subtract unit
// Assumes: 40 MHz clock, registers over AXI4-Lite
// Notes: Polls busy instead of counting cycles
`timescale 1ns/1ps
`include "halt_sub_map.vh"
module sleep_instr_and_sub_carry_tb;
  reg i_clk = 0, i_rstn = 0, i_ce = 1;
  reg [3:0] i_awaddr = 0, i_wstrb = 4'hf, i_araddr = 0;
  reg [31:0] i_wdata = 0, s = 32'h0edc_5fa9, d;
  reg i_awvalid = 0, i_wvalid = 0, i_bready = 0;
  reg i_arvalid = 0, i_rready = 0;
  wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  wire o_osc_en, o_sleep;
  wire [1:0] o_bresp, o_rresp;
  wire [31:0] o_rdata;
  integer fails = 0, samples_checked = 0, i;
  reg [7:0] a, k, p, q;
  reg [1:0] r;
  halt_sub_exec dut
  (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_awaddr(i_awaddr),
    .i_awvalid(i_awvalid),
    .o_awready(o_awready),
    .i_wdata(i_wdata),
    .i_wstrb(i_wstrb),
    .i_wvalid(i_wvalid),
    .o_wready(o_wready),
    .o_bresp(o_bresp),
    .o_bvalid(o_bvalid),
    .i_bready(i_bready),
    .i_araddr(i_araddr),
    .i_arvalid(i_arvalid),
    .o_arready(o_arready),
    .o_rdata(o_rdata),
    .o_rresp(o_rresp),
    .o_rvalid(o_rvalid),
    .i_rready(i_rready),
    .o_osc_en(o_osc_en),
    .o_sleep(o_sleep)
  );
  function [31:0] nx(input [31:0] v);
    nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function [7:0] df(input [7:0] x, input [7:0] y);
    df = x - y;
  endfunction
  task ck(input [31:0] g, input [31:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e)
      begin
        fails = fails + 1;
        $display("MISMATCH %0t got %h want %h", $time, g, e);
      end
    end
  endtask
  task wr(input [3:0] ad, input [31:0] v);
    reg ta, tw, tb;
    begin
      @(posedge i_clk);
      i_awaddr <= ad;
      i_wdata <= v;
      i_awvalid <= 1;
      i_wvalid <= 1;
      i_bready <= 1;
      tb = 0;
      while (!tb)
      begin
        @(negedge i_clk);
        ta = i_awvalid & o_awready;
        tw = i_wvalid & o_wready;
        tb = o_bvalid;
        r = o_bresp;
        @(posedge i_clk);
        if (ta) i_awvalid <= 0;
        if (tw) i_wvalid <= 0;
      end
      i_bready <= 0;
    end
  endtask
  task rd(input [3:0] ad);
    reg ta, tr;
    begin
      @(posedge i_clk);
      i_araddr <= ad;
      i_arvalid <= 1;
      i_rready <= 1;
      tr = 0;
      while (!tr)
      begin
        @(negedge i_clk);
        ta = i_arvalid & o_arready;
        tr = o_rvalid;
        d = o_rdata;
        r = o_rresp;
        @(posedge i_clk);
        if (ta) i_arvalid <= 0;
      end
      i_rready <= 0;
    end
  endtask
  task conclude;
    begin
      if (fails == 0 && samples_checked > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial
  begin
    forever #12.5 i_clk = ~i_clk;
  end
  // Generous span: each access takes only a handful of cycles
  initial
  begin
    repeat (20000) @(posedge i_clk);
    fails = fails + 1;
    conclude;
  end
  initial
  begin
    repeat (5) @(posedge i_clk);
    i_rstn <= 1;
    rd(`STATUS_OFS);
    ck(d[2:0], 3'b110);
    // Negative, zero, positive corners first, last pass zero again
    for (i = 0; i < 12; i = i + 1)
    begin
      s = nx(s);
      a = i < 3 ? 3 - i : s[7:0];
      k = i < 3 ? 2 : (i == 11 ? a : s[15:8]);
      wr(`ACC_OFS, a);
      wr(`INSTR_OFS, `OPC_SUBL_VAL | k);
      do rd(`STATUS_OFS); while (d[4]);
      ck(d[0], k >= a);
      rd(`ACC_OFS);
      ck(d[7:0], df(k, a));
    end
    wr(`STATUS_OFS, 32'h0000_0000);
    ck(r, `RESP_SLVERR);
    wr(`CTRL_OFS, 32'h0000_0002);
    ck(r, `RESP_OKAY);
    rd(`CTRL_OFS);
    ck(r, `RESP_OKAY);
    ck(d[7:0], 8'h00);
    ck(d[15:8] < 8'h08, 1'b1);
    // Clock enable low must freeze the prescaler: same step with a pause
    rd(`CTRL_OFS);
    p = d[15:8];
    rd(`CTRL_OFS);
    q = d[15:8] - p;
    p = d[15:8];
    i_ce <= 1'b0;
    repeat (100) @(posedge i_clk);
    i_ce <= 1'b1;
    rd(`CTRL_OFS);
    p = d[15:8] - p;
    ck(p, q);
    wr(`INSTR_OFS, `OPC_HALT);
    rd(`STATUS_OFS);
    ck(d[3:0], 4'b1101);
    ck({o_sleep, o_osc_en}, 2'b10);
    rd(`CTRL_OFS);
    ck(d[15:0], 16'h0000);
    rd(4'h2);
    ck(r, `RESP_SLVERR);
    wr(`CTRL_OFS, 32'h0000_0001);
    rd(`STATUS_OFS);
    ck({d[3], o_osc_en}, 2'b01);
    conclude;
  end
endmodule
